// file: shared/copy_seq_consts.svh
// timing counts, register offsets, field positions and reset values of the copy sequencer
`ifndef COPY_SEQ_CONSTS_SVH
`define COPY_SEQ_CONSTS_SVH

// ============================================================
// clock and common timebase
`define CLK_PERIOD_NS   50
`define TICK_NS         10000
`define TICK_CYC        (`TICK_NS / `CLK_PERIOD_NS)

// ============================================================
// intervals, each as printed, then its count
`define STROBE_NS       2000
`define STROBE_CYC      ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STAGE_US        9090
`define STAGE_TK        ((`STAGE_US * 1000) / `TICK_NS)
`define PUNCH_GATE_US   4000
`define PUNCH_GATE_TK   ((`PUNCH_GATE_US * 1000) / `TICK_NS)
`define FINAL_STAGE     4'h9
`define FINAL_LEN       4'h2

// ============================================================
// register offsets
`define ADDR_CTRL       4'h0
`define ADDR_STATUS     4'h4
`define ADDR_OUTREG     4'h8

// ============================================================
// control register field positions
`define CTRL_CONT_BIT   0
`define CTRL_STEP_BIT   1
`define CTRL_RPP_BIT    2
`define CTRL_GCLR_BIT   3

// ============================================================
// reset values
`define RST_SHIFTER_IDLE 1'b1
`define RST_OUTREG       8'h00

`endif

// file: shared/copy_seq_pkg.sv
// types shared by the copy sequencer modules
package copy_seq_pkg;

  // synchronised pin levels
  typedef struct packed {
    logic punch_rdy;
    logic print_rdy;
    logic flywheel;
    logic eot;
    logic kb_busy;
  } pins_t;

  // status word, bit 0 is continuous
  typedef struct packed {
    logic [3:0] stage;
    logic       ser_busy;
    logic       shifter_idle;
    logic       punch_gate;
    logic       punch_cycle;
    logic       printer;
    logic       single_frame;
    logic       continuous;
  } status_t;

  // punch cycle latch states
  typedef enum logic [2:0] {
    P_IDLE  = 3'b001,
    P_ARMED = 3'b010,
    P_GATED = 3'b100
  } punch_st_t;

endpackage : copy_seq_pkg

// file: core/serializer_chain.sv
// serializer delay chain: stages of one stage time each, final stage two long
`timescale 1ns/1ns
`include "copy_seq_consts.svh"
module serializer_chain #(
  parameter logic [9:0] STAGE_TK = 10'(`STAGE_TK)
)(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       launch,
  output logic            busy_q,
  output logic [3:0]      stage_q,
  output logic            final_gate_q,
  output logic            final_start_q
);

  logic [9:0] sub_q, sub_d;
  logic [3:0] stage_d;
  logic       busy_d, final_gate_d, final_start_d;

  // next state: a launch is only taken while the chain is idle
  always_comb begin
    busy_d        = busy_q;
    stage_d       = stage_q;
    sub_d         = sub_q;
    final_gate_d  = final_gate_q;
    final_start_d = 1'b0;
    if (launch && !busy_q) begin                       // [RULE_08]
      busy_d  = 1'b1;
      stage_d = 4'h0;
      sub_d   = 10'h000;
    end else if (busy_q && tick) begin
      if (sub_q == STAGE_TK - 10'h001) begin
        sub_d   = 10'h000;
        stage_d = stage_q + 4'h1;                      // [RULE_08]
        if (stage_q + 4'h1 == `FINAL_STAGE) begin
          final_start_d = 1'b1;                        // [RULE_09]
          final_gate_d  = 1'b1;
        end
        if (stage_q + 4'h1 == `FINAL_STAGE + `FINAL_LEN) begin
          busy_d       = 1'b0;                         // [RULE_09]
          final_gate_d = 1'b0;
          stage_d      = 4'h0;
        end
      end else begin
        sub_d = sub_q + 10'h001;
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_q        <= 1'b0;
      stage_q       <= 4'h0;
      sub_q         <= 10'h000;
      final_gate_q  <= 1'b0;
      final_start_q <= 1'b0;
    end else begin
      busy_q        <= busy_d;
      stage_q       <= stage_d;
      sub_q         <= sub_d;
      final_gate_q  <= final_gate_d;
      final_start_q <= final_start_d;
    end
  end

endmodule : serializer_chain

// file: core/offline_copy_sequencer.sv
// off-line tape copy sequencer: reader frame to punch and printer serializer
//
// Function
// RULE_01: transfer strobe sets printer latch when printer is spun up.
// RULE_02: printer latch set holds the output register against clearing.
// RULE_03: printer latch set launches serializer unless keyboard busy, if shifter idle.
// RULE_04: armed punch cycle plus flywheel pulse starts a 4 ms data gate.
// RULE_05: during data gate each punch line follows its output register bit.
// RULE_06: sprocket hole drive is active for the whole data gate.
// RULE_07: after the gate began, flywheel pulse end clears the punch cycle latch.
// RULE_08: launch starts a chain of 9.09 ms stages.
// RULE_09: final 18.18 ms stage at 81.81 ms sets shifter idle, clears printer latch.
// RULE_10: serializer launches only while shifter idle is set.
// RULE_11: output register clears when printer, punch cycle and gate are all idle.
// RULE_12: clear condition with both machines spun up raises simulated input ack.
// RULE_13: simulated input ack gives one 2 us single-frame clear pulse.
// RULE_14: final serializer gate inhibits setting the single-frame latch; only the continuous path is gated, a step write still sets it.
// RULE_15: at gate end single-frame latch sets again if continuous copy is set.
// RULE_16: end of tape, clear controls, single-frame select or global clear stop reading.
// RULE_17: single-frame mode keeps continuous clear; each step moves exactly one frame.
// RULE_18: transfer strobe copies input register bits into output register.
// RULE_19: transfer strobe arms the punch cycle only when punch is spun up.
// RULE_20: intervals come from one common timebase and are parameters; the 2 us pulses are fixed STROBE_CYC clock counts.
`timescale 1ns/1ns
`include "copy_seq_consts.svh"
module offline_copy_sequencer import copy_seq_pkg::*; #(
  parameter logic [7:0] TICK_CYC = 8'(`TICK_CYC),
  parameter logic [9:0] STAGE_TK = 10'(`STAGE_TK),
  parameter logic [8:0] PUNCH_TK = 9'(`PUNCH_GATE_TK)
)(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rd_data,
  input  wire logic        punch_spun_up,
  input  wire logic        printer_spun_up,
  input  wire logic        punch_flywheel,
  input  wire logic        end_of_tape,
  input  wire logic        keyboard_busy,
  input  wire logic [7:0]  input_register_bits,
  output logic [7:0]       output_register_bits,
  output logic [7:0]       punch_bit_lines,
  output logic             sprocket_hole_drive,
  output logic             serializer_launch,
  output logic             printer_output_active,
  output logic             punch_cycle_active,
  output logic             shifter_idle_flag,
  output logic             reader_frame_request,
  output logic             simulated_input_ack,
  output logic             single_frame_clear_pulse,
  output logic [3:0]       serializer_stage
);

  // ==========================================================
  // pin synchronisers
  logic [4:0] sync1_q, sync2_q;
  pins_t      pin;

  // two flops before any logic sees a pin level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {punch_spun_up, printer_spun_up, punch_flywheel, end_of_tape, keyboard_busy};
      sync2_q <= sync1_q;
    end
  end
  assign pin = pins_t'(sync2_q);

  // ==========================================================
  // state declarations
  logic [7:0]  tick_cnt_q, tick_cnt_d;
  logic        tick_q, tick_d;
  logic        continuous_q, continuous_d;
  logic        single_frame_d, sf_prev_q;
  logic [5:0]  strobe_cnt_q, strobe_cnt_d;
  logic [5:0]  clr_cnt_q, clr_cnt_d;
  logic        clr_pulse_d;
  logic        printer_d, shifter_idle_d, launch_d;
  punch_st_t   punch_q, punch_d;
  logic        gate_q, gate_d;
  logic [8:0]  gate_cnt_q, gate_cnt_d;
  logic        fly_prev_q;
  logic [7:0]  out_reg_d, punch_bits_d;
  logic        sprocket_d;
  logic        ack_cond, ack_prev_q, sim_ack_d;
  logic [31:0] rd_data_d;
  logic        ctrl_wr, step, stop, xfer_start, clr_cond, fly_rise, fly_fall;
  logic        ser_busy, ser_final_gate, ser_final_start;
  status_t     status;

  // serializer delay chain, fed by the launch flop
  serializer_chain #(
    .STAGE_TK (STAGE_TK)
  ) u_chain (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .tick          (tick_q),
    .launch        (serializer_launch),
    .busy_q        (ser_busy),
    .stage_q       (serializer_stage),
    .final_gate_q  (ser_final_gate),
    .final_start_q (ser_final_start)
  );

  // ==========================================================
  // decoded events from current state
  always_comb begin
    ctrl_wr    = wr_en && (addr == `ADDR_CTRL);
    step       = ctrl_wr && wr_data[`CTRL_STEP_BIT];
    // clear controls and tape end drop the frame request; single-frame
    // select only clears continuous, so a step write can still set it
    stop       = pin.eot                                              // [RULE_16]
               || (ctrl_wr && (wr_data[`CTRL_RPP_BIT] || wr_data[`CTRL_GCLR_BIT]));
    xfer_start = reader_frame_request && !sf_prev_q;                  // simulated output ack
    clr_cond   = !printer_output_active && (punch_q == P_IDLE) && !gate_q; // [RULE_11]
    ack_cond   = clr_cond && pin.punch_rdy && pin.print_rdy;          // [RULE_12]
    fly_rise   = pin.flywheel && !fly_prev_q;
    fly_fall   = !pin.flywheel && fly_prev_q;
  end

  // ==========================================================
  // next values of all sequencing state
  always_comb begin
    // common timebase: one tick every TICK_CYC clocks
    tick_d     = (tick_cnt_q == TICK_CYC - 8'h01);                   // [RULE_20]
    tick_cnt_d = tick_d ? 8'h00 : tick_cnt_q + 8'h01;

    // continuous copy latch; a write with the bit clear selects single-frame
    continuous_d = continuous_q;
    if (stop || (ctrl_wr && !wr_data[`CTRL_CONT_BIT])) begin
      continuous_d = 1'b0;                                            // [RULE_16] [RULE_17]
    end else if (ctrl_wr && wr_data[`CTRL_CONT_BIT]) begin
      continuous_d = 1'b1;
    end

    // single-frame latch: clear pulse and stops win over the set paths
    single_frame_d = reader_frame_request;
    if (stop || single_frame_clear_pulse) begin
      single_frame_d = 1'b0;                                          // [RULE_13]
    end else if (step) begin
      single_frame_d = 1'b1;                                          // [RULE_17]
    end else if (continuous_q && !ser_busy && !ser_final_gate) begin  // [RULE_14]
      single_frame_d = 1'b1;                                          // [RULE_15]
    end

    // 2 us output transfer strobe, counted down from its start
    strobe_cnt_d = (strobe_cnt_q != 6'h00) ? strobe_cnt_q - 6'h01 : 6'h00;
    if (xfer_start) begin
      strobe_cnt_d = 6'(`STROBE_CYC);
    end

    // simulated input ack on the rising edge of its condition
    sim_ack_d = ack_cond && !ack_prev_q;                              // [RULE_12]
    clr_cnt_d = (clr_cnt_q != 6'h00) ? clr_cnt_q - 6'h01 : 6'h00;
    if (sim_ack_d) begin
      clr_cnt_d = 6'(`STROBE_CYC);                                    // [RULE_13]
    end
    clr_pulse_d = (clr_cnt_d != 6'h00);

    // printer latch, shifter idle and launch
    printer_d      = printer_output_active;
    shifter_idle_d = shifter_idle_flag;
    launch_d       = 1'b0;
    if (ser_final_start) begin
      shifter_idle_d = 1'b1;                                          // [RULE_09]
      printer_d      = 1'b0;                                          // [RULE_09]
    end
    if (xfer_start && pin.print_rdy) begin
      printer_d = 1'b1;                                               // [RULE_01]
      // keyboard use blocks the launch; the latch then waits for a clear
      if (!pin.kb_busy && shifter_idle_flag) begin                    // [RULE_10]
        launch_d       = 1'b1;                                        // [RULE_03]
        shifter_idle_d = 1'b0;
      end
    end

    // punch cycle latch and data gate
    punch_d    = punch_q;
    gate_d     = gate_q;
    gate_cnt_d = gate_cnt_q;
    if (gate_q && tick_q) begin
      gate_cnt_d = gate_cnt_q - 9'h001;
      if (gate_cnt_q == 9'h001) begin
        gate_d = 1'b0;                                                // [RULE_04]
      end
    end
    unique case (punch_q)
      P_IDLE: begin
        if (xfer_start && pin.punch_rdy) begin
          punch_d = P_ARMED;                                          // [RULE_19]
        end
      end
      P_ARMED: begin
        if (fly_rise) begin
          punch_d    = P_GATED;
          gate_d     = 1'b1;                                          // [RULE_04]
          gate_cnt_d = PUNCH_TK;
        end
      end
      P_GATED: begin
        if (fly_fall) begin
          punch_d = P_IDLE;                                           // [RULE_07]
        end
      end
    endcase

    // output register: copy has priority, then the clear path
    out_reg_d = output_register_bits;
    if (xfer_start) begin
      out_reg_d = input_register_bits;                                // [RULE_18]
    end else if (clr_cond) begin
      // printer latch, punch cycle latch or punch gate keeps the frame held
      out_reg_d = `RST_OUTREG;                                        // [RULE_02] [RULE_11]
    end

    // punch lines follow the gate in the same cycle as gate_q
    punch_bits_d = gate_d ? out_reg_d : 8'h00;                        // [RULE_05]
    sprocket_d   = gate_d;                                            // [RULE_06]

    // register read port, data stands one cycle after the strobe
    status = '{stage:        serializer_stage,
               ser_busy:     ser_busy,
               shifter_idle: shifter_idle_flag,
               punch_gate:   gate_q,
               punch_cycle:  (punch_q != P_IDLE),
               printer:      printer_output_active,
               single_frame: reader_frame_request,
               continuous:   continuous_q};
    rd_data_d = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        `ADDR_CTRL:   rd_data_d = {31'h0000_0000, continuous_q};
        `ADDR_STATUS: rd_data_d = 32'(status);
        `ADDR_OUTREG: rd_data_d = {24'h00_0000, output_register_bits};
        default:      rd_data_d = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // registers only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt_q               <= 8'h00;
      tick_q                   <= 1'b0;
      continuous_q             <= 1'b0;
      reader_frame_request     <= 1'b0;
      sf_prev_q                <= 1'b0;
      strobe_cnt_q             <= 6'h00;
      clr_cnt_q                <= 6'h00;
      single_frame_clear_pulse <= 1'b0;
      ack_prev_q               <= 1'b0;
      simulated_input_ack      <= 1'b0;
      printer_output_active    <= 1'b0;
      shifter_idle_flag        <= `RST_SHIFTER_IDLE;
      serializer_launch        <= 1'b0;
      punch_q                  <= P_IDLE;
      punch_cycle_active       <= 1'b0;
      gate_q                   <= 1'b0;
      gate_cnt_q               <= 9'h000;
      fly_prev_q               <= 1'b0;
      output_register_bits     <= `RST_OUTREG;
      punch_bit_lines          <= 8'h00;
      sprocket_hole_drive      <= 1'b0;
      rd_data                  <= 32'h0000_0000;
    end else begin
      tick_cnt_q               <= tick_cnt_d;
      tick_q                   <= tick_d;
      continuous_q             <= continuous_d;
      reader_frame_request     <= single_frame_d;
      sf_prev_q                <= reader_frame_request;
      strobe_cnt_q             <= strobe_cnt_d;
      clr_cnt_q                <= clr_cnt_d;
      single_frame_clear_pulse <= clr_pulse_d;
      ack_prev_q               <= ack_cond;
      simulated_input_ack      <= sim_ack_d;
      printer_output_active    <= printer_d;
      shifter_idle_flag        <= shifter_idle_d;
      serializer_launch        <= launch_d;
      punch_q                  <= punch_d;
      punch_cycle_active       <= (punch_d != P_IDLE);
      gate_q                   <= gate_d;
      gate_cnt_q               <= gate_cnt_d;
      fly_prev_q               <= pin.flywheel;
      output_register_bits     <= out_reg_d;
      punch_bit_lines          <= punch_bits_d;
      sprocket_hole_drive      <= sprocket_d;
      rd_data                  <= rd_data_d;
    end
  end

endmodule : offline_copy_sequencer

// file: verif/copy_seq_checker.sv
// port assertions for the off-line copy sequencer
`timescale 1ns/1ns
`include "copy_seq_consts.svh"
module copy_seq_checker #(
  parameter logic [7:0] TICK_CYC = 8'h04,
  parameter logic [9:0] STAGE_TK = 10'h003,
  parameter logic [8:0] PUNCH_TK = 9'h002
)(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] output_register_bits,
  input wire logic [7:0] punch_bit_lines,
  input wire logic       sprocket_hole_drive,
  input wire logic       serializer_launch,
  input wire logic       printer_output_active,
  input wire logic       punch_cycle_active,
  input wire logic       shifter_idle_flag,
  input wire logic       reader_frame_request,
  input wire logic       simulated_input_ack,
  input wire logic       single_frame_clear_pulse
);
  // ============================================================
  // bounds in cycles; a stage or gate may start one tick short
  localparam int ST      = STAGE_TK * TICK_CYC;
  localparam int FIN_LO  = 9 * ST - TICK_CYC;
  localparam int FIN_HI  = 9 * ST + 2;
  localparam int GATE_HI = PUNCH_TK * TICK_CYC;
  localparam int GATE_LO = GATE_HI - TICK_CYC;
  logic [7:0] clr_len_q, clr_len_d, gate_len_q, gate_len_d;

  // ============================================================
  // burst length counters, cleared while low so each counts one burst
  always_comb begin
    clr_len_d  = single_frame_clear_pulse ? clr_len_q + 8'h01 : 8'h00;
    gate_len_d = sprocket_hole_drive ? gate_len_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge ref_clk) begin
    clr_len_q  <= rst ? 8'h00 : clr_len_d;
    gate_len_q <= rst ? 8'h00 : gate_len_d;
  end

  // ============================================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_fin_start;
    $rose(shifter_idle_flag) && !printer_output_active;
  endsequence
  sequence s_ack_clear;
    simulated_input_ack ##[0:1] single_frame_clear_pulse;
  endsequence
  chk_punch_data: assert property (
    sprocket_hole_drive |-> punch_bit_lines == output_register_bits)
    else $error("punch lines differ from output register");
  chk_gate_hold: assert property (
    sprocket_hole_drive |-> $stable(output_register_bits))
    else $error("output register changed during punch gate");
  chk_gate_len: assert property (
    $fell(sprocket_hole_drive) |-> gate_len_q >= GATE_LO && gate_len_q <= GATE_HI)
    else $error("punch gate length wrong");
  chk_launch_idle: assert property (
    serializer_launch |-> $past(shifter_idle_flag))
    else $error("launch without shifter idle");
  chk_launch_print: assert property (
    serializer_launch |-> printer_output_active)
    else $error("launch without printer latch");
  chk_final_time: assert property (
    serializer_launch |-> ##[FIN_LO:FIN_HI] s_fin_start)
    else $error("final stage late, early or printer latch kept");
  chk_ack_cond: assert property (
    simulated_input_ack |-> !printer_output_active && !punch_cycle_active
      && !sprocket_hole_drive)
    else $error("input ack while output register held");
  chk_out_clear: assert property (
    simulated_input_ack |-> ##[0:1] output_register_bits == 8'h00)
    else $error("output register not cleared");
  chk_ack_pulse: assert property (
    simulated_input_ack |-> s_ack_clear)
    else $error("no clear pulse after input ack");
  chk_clr_len: assert property (
    $fell(single_frame_clear_pulse) |-> clr_len_q == 8'(`STROBE_CYC))
    else $error("clear pulse length wrong");
  chk_frame_drop: assert property (
    $fell(single_frame_clear_pulse) |-> !reader_frame_request)
    else $error("frame request survived clear pulse");
endmodule : copy_seq_checker

bind offline_copy_sequencer copy_seq_checker #(
  .TICK_CYC(TICK_CYC), .STAGE_TK(STAGE_TK), .PUNCH_TK(PUNCH_TK)
) u_chk (
  .ref_clk, .rst, .output_register_bits, .punch_bit_lines, .sprocket_hole_drive,
  .serializer_launch, .printer_output_active, .punch_cycle_active, .shifter_idle_flag,
  .reader_frame_request, .simulated_input_ack, .single_frame_clear_pulse
);

// file: verif/tape_devices_model.sv
// model of the punch, printer and tape reader beside the copy sequencer
`timescale 1ns/1ns
module tape_devices_model (
  input  wire logic ref_clk,
  input  wire logic spin,
  input  wire logic reader_frame_request,
  output logic      punch_spun_up,
  output logic      printer_spun_up,
  output logic      punch_flywheel,
  output logic [7:0] input_register_bits
);
  int   fly_cnt;
  logic req_seen;

  initial begin
    punch_spun_up = 1'b0;
    printer_spun_up = 1'b0;
    punch_flywheel = 1'b0;
    input_register_bits = 8'h5a;
    fly_cnt = 0;
    req_seen = 1'b0;
  end

  // ============================================================
  // motors follow spin; the flywheel turns only with the punch motor.
  // a new frame is loaded when a request ends, so it is steady long
  // before the next request rises
  always @(posedge ref_clk) begin
    punch_spun_up <= spin;
    printer_spun_up <= spin;
    fly_cnt <= (fly_cnt == 29) ? 0 : fly_cnt + 1;
    punch_flywheel <= spin && (fly_cnt < 6);
    req_seen <= reader_frame_request;
    if (!reader_frame_request && req_seen) input_register_bits <= 8'($urandom);
  end
endmodule : tape_devices_model

// file: verif/tb_top.sv
// self-checking bench for the off-line copy sequencer
`timescale 1ns/1ns
module tb_top import copy_seq_pkg::*;;
  logic        ref_clk, rst, wr_en, rd_en, spin, end_of_tape, keyboard_busy;
  logic [3:0]  addr, serializer_stage;
  logic [31:0] wr_data, rd_data, d;
  logic [7:0]  input_register_bits, output_register_bits, punch_bit_lines;
  logic        punch_spun_up, printer_spun_up, punch_flywheel, sprocket_hole_drive;
  logic        serializer_launch, printer_output_active, punch_cycle_active;
  logic        shifter_idle_flag, reader_frame_request, simulated_input_ack;
  logic        single_frame_clear_pulse, req_seen, arm_seen;
  int          miscompares = 0, num_checks = 0, launches = 0, exp_out = 0, n;
  int          q[$];
  logic [31:0] stop_val [3] = '{32'h0, 32'h5, 32'h9};

  // short counts keep a frame near 150 cycles
  offline_copy_sequencer #(.TICK_CYC(8'h04), .STAGE_TK(10'h003), .PUNCH_TK(9'h002)) DUT (
    .ref_clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .punch_spun_up,
    .printer_spun_up, .punch_flywheel, .end_of_tape, .keyboard_busy,
    .input_register_bits, .output_register_bits, .punch_bit_lines, .sprocket_hole_drive,
    .serializer_launch, .printer_output_active, .punch_cycle_active, .shifter_idle_flag,
    .reader_frame_request, .simulated_input_ack, .single_frame_clear_pulse,
    .serializer_stage
  );
  tape_devices_model u_dev (
    .ref_clk, .spin, .reader_frame_request, .punch_spun_up, .printer_spun_up,
    .punch_flywheel, .input_register_bits
  );

  always #25 ref_clk = ~ref_clk;

  // ============================================================
  // tasks
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    // data stand for this one cycle; take them at the edge that closes it
    @(posedge ref_clk);
    v = rd_data;
  endtask : rd

  task automatic settle(input int cyc);
    repeat (cyc) @(posedge ref_clk);
  endtask : settle

  // bounded wait for a launch count
  task automatic wait_for(input int target, input int lim);
    for (int i = 0; i < lim && launches < target; i++) @(posedge ref_clk);
  endtask : wait_for

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  // ============================================================
  // frame model: queue of offered frames, popped at each transfer
  always @(negedge ref_clk) begin
    if (rst) q.delete();
    else begin
      if (reader_frame_request && !req_seen) q.push_back(input_register_bits);
      if (punch_cycle_active && !arm_seen && q.size() > 0) begin
        exp_out = q.pop_front();
        cmp("output register", 32'(exp_out), 32'(output_register_bits));
      end
      if (serializer_launch) launches++;
      if (sprocket_hole_drive) cmp("punch lines", 32'(exp_out), 32'(punch_bit_lines));
    end
    req_seen = reader_frame_request;
    arm_seen = punch_cycle_active;
  end

  // ============================================================
  // main sequence
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    addr = 4'h0;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    spin = 1'b0;
    end_of_tape = 1'b0;
    keyboard_busy = 1'b0;
    void'($urandom(27));
    settle(12);
    rst <= 1'b0;
    spin <= 1'b1;
    settle(20);
    rd(4'h4, d);
    cmp("status after reset", 32'h20, d);
    rd(4'hc, d);
    cmp("unmapped read", 32'h0, d);
    $display("test reset done");
    // continuous copy re-arms the reader after every frame
    wr(4'h0, 32'h1);
    rd(4'h0, d);
    cmp("control readback", 32'h1, d);
    n = launches;
    wait_for(n + 3, 800);
    cmp("continuous frames", n + 3, launches);
    $display("test continuous done");
    // each stop cause in mid-run: single select, clear controls, global clear, tape end
    for (int k = 0; k < 4; k++) begin
      wr(4'h0, 32'h1);
      wait_for(launches + 1, 400);
      if (k == 3) end_of_tape <= 1'b1;
      else wr(4'h0, stop_val[k]);
      settle(300);
      n = launches;
      settle(300);
      cmp("launches after stop", n, launches);
      cmp("request after stop", 32'h0, 32'(reader_frame_request));
      end_of_tape <= 1'b0;
      $display("test stop %0d done", k);
    end
    // single step moves exactly one frame
    wr(4'h0, 32'h0);
    settle(300);
    n = launches;
    wr(4'h0, 32'h2);
    settle(400);
    cmp("frames per step", n + 1, launches);
    $display("test step done");
    // keyboard busy blocks the launch; latch keeps the frame held
    keyboard_busy <= 1'b1;
    settle(4);
    n = launches;
    wr(4'h0, 32'h2);
    settle(300);
    cmp("launch while keyboard busy", n, launches);
    cmp("printer latch", 32'h1, 32'(printer_output_active));
    rd(4'h8, d);
    cmp("output register held", 32'(exp_out), d);
    $display("test keyboard done");
    // second reset in mid-run
    rst <= 1'b1;
    keyboard_busy <= 1'b0;
    settle(12);
    rst <= 1'b0;
    settle(4);
    rd(4'h4, d);
    cmp("status after second reset", 32'h20, d);
    $display("test second reset done");
    end_sim();
  end

  // run needs about 4000 cycles; the limit allows five times that
  initial begin
    settle(20000);
    miscompares++;
    $display("Error watchdog expected end seen timeout");
    end_sim();
  end
endmodule : tb_top
